// ===== rtl/ibmta_pkg.sv
/*
  Constants, field layouts and carrier types for the instrument bus port.
  Assumes one 100 MHz system clock and logical (true = asserted) line levels.
*/
package ibmta_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_BUSCFG = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int ROLE_LSB = 0;
  localparam int CONTENT_LSB = 4;
  localparam int TERM_BIT = 0;
  localparam int ENC_BIT = 1;
  localparam int ADDR_LSB = 8;
  localparam int TX_BIT = 0;
  localparam int SRQ_BIT = 1;
  localparam int ERRCLR_BIT = 2;
  localparam int ST_ERR_BIT = 16;
  localparam int ST_BUSY_BIT = 17;
  localparam int ST_TADS_BIT = 18;
  localparam int ST_LADS_BIT = 19;
  localparam int ST_SRQ_BIT = 20;

  // ----------------------------------------------------------------
  // Bus roles, content options, message parts
  // ----------------------------------------------------------------
  localparam logic [2:0] ROLE_TALK_ONLY = 3'h0;
  localparam logic [2:0] ROLE_LISTEN_ONLY = 3'h1;
  localparam logic [2:0] ROLE_TALK_LISTEN = 3'h2;
  localparam logic [2:0] ROLE_HARDCOPY = 3'h3;
  localparam logic [2:0] ROLE_DETACHED = 3'h4;
  localparam logic [1:0] CONT_SAMPLES = 2'h0;
  localparam logic [1:0] CONT_HDR_SAMPLES = 2'h1;
  localparam logic [1:0] CONT_PROGRAM = 2'h2;
  localparam logic [1:0] PART_REPLY = 2'h0;
  localparam logic [1:0] PART_HEADER = 2'h1;
  localparam logic [1:0] PART_SAMPLES = 2'h2;
  localparam logic [1:0] PART_PROGRAM = 2'h3;

  // ----------------------------------------------------------------
  // Reset values, address range, bus command and character codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ROLE_RST = ROLE_TALK_LISTEN;
  localparam logic [4:0] ADDR_RST = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3f;
  localparam logic [6:0] CMD_UNTALK = 7'h5f;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_SEND = 5'h04,
    ST_CR = 5'h08,
    ST_LF = 5'h10
  } ibmta_fsm_e;

  typedef struct packed {
    logic [7:0] dio;
    logic eoi;
    logic atn;
    logic dav;
    logic lsn_present;
    logic lsn_ready;
  } ibmta_bus_in_s;

  typedef struct packed {
    logic [7:0] dio;
    logic dio_oe;
    logic eoi;
    logic eoi_oe;
    logic dav;
    logic dav_oe;
    logic srq;
    logic srq_oe;
  } ibmta_bus_out_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic valid;
  } ibmta_src_s;

  typedef struct packed {
    logic [7:0] data;
    logic msg_end;
    logic valid;
  } ibmta_rx_s;

  typedef struct packed {
    logic [2:0] role;
    logic [1:0] content;
    logic pend_term;
    logic pend_enc;
    logic [4:0] pend_addr;
    logic term_lf;
    logic enc;
    logic [4:0] addr;
    logic tads;
    logic lads;
    ibmta_fsm_e fsm;
    logic [1:0] part;
    logic err;
    logic srq_req;
    ibmta_bus_out_s bus;
    logic src_ready;
    ibmta_rx_s rx;
    logic [31:0] rd_data;
  } ibmta_state_s;

endpackage

// ===== rtl/ibmta_port.sv
/*
  Device-side instrument bus port: role control, talker/listener state,
  message output with terminators, message input with end detection.
  Assumes all inputs synchronous to ref_clk and the three-wire handshake
  reduced to a dav strobe plus listener-ready and listener-present senses.
*/
// The strobed register port and the register offsets are this design's own decisions.
// Functional notes
// - Talk-only role is always addressed to talk, no controller needed
// - Talk-only ignores incoming commands and never raises service request
// - Talk-only transmit checks a listener is present, else flags error
// - Samples-only content sends only sample points of displayed waveforms
// - Header-and-samples content sends header then sample points
// - Program dump sends the selected stored program; options exclusive
// - Listen-only acts as listener only, ignores commands, never sends
// - Talk-listen accepts data when listener, replies when talker
// - Bus role cannot be changed over the bus, only locally
// - Detached role drives no lines and disables transmit
// - Terminator, address, encoding changes while detached stay pending
// - Eoi-only terminator: eoi with final byte, nothing appended
// - Linefeed terminator appends CR then Linefeed_plus_end_terminator with LF
// - Any received byte with eoi ends the incoming message
// - With linefeed terminator, received LF also ends message
// - Eoi always accompanies the last outgoing byte
// - One primary address for talk and listen, range 0 to 30
// - Linefeed-enabled receiver ends sequence transfer at first LF
`timescale 1ns/1ps
`default_nettype none

module ibmta_port
  import ibmta_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire ibmta_bus_in_s bus_i,
  output ibmta_bus_out_s bus_o,
  input wire ibmta_src_s src_i,
  output logic src_ready,
  output logic [1:0] src_part,
  output ibmta_rx_s rx_o,
  output logic enc_sel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ibmta_state_s s_q;
  ibmta_state_s s_d;
  logic listening;
  logic talker_role;
  logic trig;
  logic slot;
  logic final_byte;
  logic [6:0] cmd;

  always_comb
  begin
    s_d = s_q;
    s_d.src_ready = 1'b0;
    s_d.rx.valid = 1'b0;
    s_d.rx.msg_end = 1'b0;
    s_d.bus.dav = 1'b0;
    s_d.bus.dav_oe = 1'b0;
    s_d.bus.dio_oe = 1'b0;
    s_d.bus.eoi = 1'b0;
    s_d.bus.eoi_oe = 1'b0;
    s_d.rd_data = 32'h0;
    cmd = bus_i.dio[6:0];
    talker_role = (s_q.role == ROLE_TALK_ONLY) ||
                  (s_q.role == ROLE_HARDCOPY);
    listening = (s_q.role == ROLE_LISTEN_ONLY) ||
                ((s_q.role == ROLE_TALK_LISTEN) && s_q.lads);
    trig = 1'b0;
    slot = !s_q.bus.dav && bus_i.lsn_ready;
    final_byte = src_i.last && (s_q.part != PART_HEADER);

    // ----------------------------------------------------------------
    // Register writes: the role is set only here, never from the bus
    // ----------------------------------------------------------------
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_MODE:
        begin
          if (reg_wdata[ROLE_LSB +: 3] <= ROLE_DETACHED)
          begin
            s_d.role = reg_wdata[ROLE_LSB +: 3];
            s_d.tads = 1'b0;
            s_d.lads = 1'b0;
          end
          // A single field keeps the content options exclusive
          if (reg_wdata[CONTENT_LSB +: 2] <= CONT_PROGRAM)
          begin
            s_d.content = reg_wdata[CONTENT_LSB +: 2];
          end
        end
        OFS_BUSCFG:
        begin
          s_d.pend_term = reg_wdata[TERM_BIT];
          s_d.pend_enc = reg_wdata[ENC_BIT];
          if (reg_wdata[ADDR_LSB +: 5] <= ADDR_MAX)
          begin
            s_d.pend_addr = reg_wdata[ADDR_LSB +: 5];
          end
        end
        OFS_CTRL:
        begin
          s_d.srq_req = reg_wdata[SRQ_BIT];
          if (reg_wdata[ERRCLR_BIT])
          begin
            s_d.err = 1'b0;
          end
          // Transmit exists only for talker roles, not when detached
          trig = reg_wdata[TX_BIT] && talker_role &&
                 (s_q.fsm == ST_IDLE);
        end
        default:
        begin
        end
      endcase
    end

    // Settings reach the bus logic only outside the detached role
    if (s_q.role != ROLE_DETACHED)
    begin
      s_d.term_lf = s_q.pend_term;
      s_d.enc = s_q.pend_enc;
      s_d.addr = s_q.pend_addr;
    end

    // ----------------------------------------------------------------
    // Addressed state per role
    // ----------------------------------------------------------------
    if (talker_role && !(reg_wr && reg_addr == OFS_MODE))
    begin
      s_d.tads = 1'b1;
      s_d.lads = 1'b0;
    end
    else if (s_q.role == ROLE_LISTEN_ONLY && !(reg_wr &&
             reg_addr == OFS_MODE))
    begin
      s_d.lads = 1'b1;
      s_d.tads = 1'b0;
    end
    else if (s_q.role == ROLE_TALK_LISTEN && bus_i.atn && bus_i.dav)
    begin
      // Commands from the bus only steer addressing, never the role
      if (cmd == CMD_UNLISTEN)
      begin
        s_d.lads = 1'b0;
      end
      else if (cmd == CMD_UNTALK)
      begin
        s_d.tads = 1'b0;
      end
      else if (cmd[6:5] == GRP_LISTEN && cmd[4:0] == s_q.addr)
      begin
        s_d.lads = 1'b1;
      end
      else if (cmd[6:5] == GRP_TALK)
      begin
        // Another talker's address untalks this one
        s_d.tads = (cmd[4:0] == s_q.addr);
      end
    end

    // ----------------------------------------------------------------
    // Receive path; talk-only roles never take bus bytes
    // ----------------------------------------------------------------
    if (listening && !bus_i.atn && bus_i.dav)
    begin
      s_d.rx.valid = 1'b1;
      s_d.rx.data = bus_i.dio;
      // LF is also data in binary transfers; eoi is the safe end
      s_d.rx.msg_end = bus_i.eoi ||
                       (s_q.term_lf && bus_i.dio == CHR_LF);
    end

    // ----------------------------------------------------------------
    // Transmit sequencer
    // ----------------------------------------------------------------
    unique case (s_q.fsm)
      ST_IDLE:
      begin
        if (s_q.role == ROLE_TALK_LISTEN)
        begin
          s_d.part = PART_REPLY;
          if (s_q.tads && !bus_i.atn && src_i.valid)
          begin
            s_d.fsm = ST_SEND;
          end
        end
        if (trig)
        begin
          s_d.fsm = ST_CHECK;
          unique case (s_q.content)
            CONT_HDR_SAMPLES: s_d.part = PART_HEADER;
            CONT_PROGRAM: s_d.part = PART_PROGRAM;
            default: s_d.part = PART_SAMPLES;
          endcase
        end
      end
      ST_CHECK:
      begin
        if (!bus_i.lsn_present)
        begin
          s_d.err = 1'b1;
          s_d.fsm = ST_IDLE;
        end
        else
        begin
          s_d.fsm = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (!talker_role && s_q.role != ROLE_TALK_LISTEN)
        begin
          s_d.fsm = ST_IDLE;
        end
        else if (slot && src_i.valid && (talker_role ||
                 (s_q.tads && !bus_i.atn)))
        begin
          s_d.bus.dio = src_i.data;
          s_d.bus.dio_oe = 1'b1;
          s_d.bus.dav = 1'b1;
          s_d.bus.dav_oe = 1'b1;
          s_d.src_ready = 1'b1;
          if (src_i.last && s_q.part == PART_HEADER)
          begin
            s_d.part = PART_SAMPLES;
          end
          if (final_byte)
          begin
            if (s_q.term_lf)
            begin
              s_d.fsm = ST_CR;
            end
            else
            begin
              s_d.bus.eoi = 1'b1;
              s_d.bus.eoi_oe = 1'b1;
              s_d.fsm = ST_IDLE;
            end
          end
        end
      end
      ST_CR:
      begin
        if (slot)
        begin
          s_d.bus.dio = CHR_CR;
          s_d.bus.dio_oe = 1'b1;
          s_d.bus.dav = 1'b1;
          s_d.bus.dav_oe = 1'b1;
          s_d.fsm = ST_LF;
        end
      end
      ST_LF:
      begin
        if (slot)
        begin
          s_d.bus.dio = CHR_LF;
          s_d.bus.dio_oe = 1'b1;
          s_d.bus.dav = 1'b1;
          s_d.bus.dav_oe = 1'b1;
          s_d.bus.eoi = 1'b1;
          s_d.bus.eoi_oe = 1'b1;
          s_d.fsm = ST_IDLE;
        end
      end
      default:
      begin
        s_d.fsm = ST_IDLE;
      end
    endcase

    // A switch to detached or listen-only mid-message abandons it rather than finishing later
    if (s_q.role == ROLE_DETACHED || s_q.role == ROLE_LISTEN_ONLY)
    begin
      s_d.fsm = ST_IDLE;
      s_d.bus.dio_oe = 1'b0;
      s_d.bus.dav_oe = 1'b0;
      s_d.bus.eoi_oe = 1'b0;
      s_d.bus.dav = 1'b0;
      s_d.bus.eoi = 1'b0;
      s_d.src_ready = 1'b0;
    end

    // Service request only in the talk-listen role
    s_d.bus.srq = s_q.srq_req && (s_q.role == ROLE_TALK_LISTEN);
    s_d.bus.srq_oe = s_d.bus.srq;

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_MODE:
        begin
          s_d.rd_data[ROLE_LSB +: 3] = s_q.role;
          s_d.rd_data[CONTENT_LSB +: 2] = s_q.content;
        end
        OFS_BUSCFG:
        begin
          s_d.rd_data[TERM_BIT] = s_q.pend_term;
          s_d.rd_data[ENC_BIT] = s_q.pend_enc;
          s_d.rd_data[ADDR_LSB +: 5] = s_q.pend_addr;
        end
        OFS_STATUS:
        begin
          s_d.rd_data[TERM_BIT] = s_q.term_lf;
          s_d.rd_data[ENC_BIT] = s_q.enc;
          s_d.rd_data[ADDR_LSB +: 5] = s_q.addr;
          s_d.rd_data[ST_ERR_BIT] = s_q.err;
          s_d.rd_data[ST_BUSY_BIT] = (s_q.fsm != ST_IDLE);
          s_d.rd_data[ST_TADS_BIT] = s_q.tads;
          s_d.rd_data[ST_LADS_BIT] = s_q.lads;
          s_d.rd_data[ST_SRQ_BIT] = s_q.bus.srq;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.role <= ROLE_RST;
      s_q.pend_addr <= ADDR_RST;
      s_q.addr <= ADDR_RST;
      s_q.fsm <= ST_IDLE;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rd_data;
  assign bus_o = s_q.bus;
  assign src_ready = s_q.src_ready;
  assign src_part = s_q.part;
  assign rx_o = s_q.rx;
  assign enc_sel = s_q.enc;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_cr_out;
    s_q.bus.dav && s_q.bus.dio == CHR_CR && !s_q.bus.eoi;
  endsequence

  sequence seq_linefeed_plus_end_terminator_out;
    s_q.bus.dav && s_q.bus.dio == CHR_LF && s_q.bus.eoi;
  endsequence

  AST_TALK_ONLY_ADDRESSED: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.role == ROLE_TALK_ONLY && $past(s_q.role == ROLE_TALK_ONLY) &&
     $past(ce) && !$past(reg_wr && reg_addr == OFS_MODE)) |->
    s_q.tads && !s_q.lads)
    else $error("talk-only not addressed to talk");

  AST_NO_SRQ_OUTSIDE_TL: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.role != ROLE_TALK_LISTEN && $stable(s_q.role)) |-> !s_q.bus.srq_oe)
    else $error("service request outside talk-listen");

  AST_NO_LISTENER_ERR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && s_q.fsm == ST_CHECK && !bus_i.lsn_present) |=>
    (s_q.err && s_q.fsm == ST_IDLE && !s_q.bus.dav))
    else $error("missing listener not flagged");

  AST_DETACHED_QUIET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.role == ROLE_DETACHED && $past(s_q.role == ROLE_DETACHED)) |->
    !(s_q.bus.dio_oe || s_q.bus.dav_oe || s_q.bus.eoi_oe ||
      s_q.bus.srq_oe || s_q.src_ready))
    else $error("detached role drives the bus");

  AST_PENDING_HELD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.role == ROLE_DETACHED && $past(s_q.role == ROLE_DETACHED)) |->
    $stable(s_q.addr) && $stable(s_q.term_lf) && $stable(s_q.enc))
    else $error("setting applied while detached");

  AST_CR_THEN_LF: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    seq_cr_out |-> ##[1:300] seq_linefeed_plus_end_terminator_out)
    else $error("CR not followed by LF with eoi");

  AST_EOI_ONLY_WITH_BYTE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.bus.eoi |-> s_q.bus.dav && s_q.bus.eoi_oe &&
    (s_q.term_lf ? s_q.bus.dio == CHR_LF : s_q.fsm == ST_IDLE))
    else $error("eoi not on final byte");

  AST_RX_EOI_END: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && listening && bus_i.dav && bus_i.eoi && !bus_i.atn) |=>
    s_q.rx.valid && s_q.rx.msg_end)
    else $error("eoi byte did not end message");

  AST_RX_LF_END: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && listening && bus_i.dav && !bus_i.atn && s_q.term_lf &&
     bus_i.dio == CHR_LF) |=> s_q.rx.valid && s_q.rx.msg_end)
    else $error("linefeed did not end message");

  AST_ADDR_RANGE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.addr <= ADDR_MAX && s_q.pend_addr <= ADDR_MAX)
    else $error("address out of range");

  AST_TALK_MATCH: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && s_q.role == ROLE_TALK_LISTEN && !reg_wr && bus_i.atn &&
     bus_i.dav && cmd[6:5] == GRP_TALK && cmd != CMD_UNTALK) |=>
    s_q.tads == ($past(cmd[4:0]) == $past(s_q.addr)))
    else $error("talk address compare wrong");

endmodule

`default_nettype wire

// ===== testbench/ibmta_peer.sv
/*
  Far-side model: bus controller plus listener peers on the instrument bus.
  Assumes logical line levels and the device's ref_clk; released lines
  read as not asserted, as the bus pull-ups leave them.
*/
`timescale 1ns/1ps
`default_nettype none

module ibmta_peer
  import ibmta_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic present,
  input wire logic slow,
  input wire ibmta_bus_out_s bus_o,
  output ibmta_bus_in_s bus_i
);
  logic [7:0] dio_q;
  logic eoi_q;
  logic atn_q;
  logic dav_q;
  logic rdy_q;
  logic [8:0] got[$];
  int msgs;

  assign bus_i = {dio_q, eoi_q, atn_q, dav_q, present, rdy_q};

  initial
  begin
    dio_q = 8'h00;
    eoi_q = 1'b0;
    atn_q = 1'b0;
    dav_q = 1'b0;
    msgs = 0;
  end

  // ----------------------------------------------------------------
  // Listeners
  // ----------------------------------------------------------------
  // A slow listener is ready only every other cycle
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      rdy_q <= 1'b0;
    else
      rdy_q <= slow ? ~rdy_q : 1'b1;

  // Only eoi closes a message: binary payloads may carry 0x0a
  always @(posedge ref_clk)
    if (bus_o.dav && bus_o.dav_oe)
    begin
      got.push_back({bus_o.eoi, bus_o.dio});
      if (bus_o.eoi) msgs++;
    end

  // ----------------------------------------------------------------
  // Controller: one byte strobe, command when atn is set
  // ----------------------------------------------------------------
  task automatic send(input logic atn, input logic [7:0] d, input logic e);
    @(posedge ref_clk);
    dio_q <= d;
    atn_q <= atn;
    eoi_q <= e;
    dav_q <= 1'b1;
    @(posedge ref_clk);
    dio_q <= 8'h00;
    atn_q <= 1'b0;
    eoi_q <= 1'b0;
    dav_q <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== testbench/tb_ibmta_port.sv
/*
  Self-checking bench for the instrument bus port.
  Assumes the peer model on the bus side and a table-driven byte source.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_ibmta_port;
  import ibmta_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic ce;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  ibmta_bus_in_s bus_i;
  ibmta_bus_out_s bus_o;
  ibmta_src_s src_i;
  logic src_ready;
  logic [1:0] src_part;
  ibmta_rx_s rx_o;
  logic enc_sel;
  logic present;
  logic slow;
  logic src_en;
  logic [3:0] src_idx;
  logic term_now;
  logic [2:0] took_q;
  logic [31:0] rdv;
  logic [8:0] exq[$];
  logic [8:0] rxq[$];
  int err_count;
  int n_compared;
  localparam logic [7:0] BASE [4] = '{8'h52, 8'h48, 8'h10, 8'h70};
  localparam logic [3:0] LEN [4] = '{4'h2, 4'h2, 4'h3, 4'h2};

  ibmta_port i_ibmta_port (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_i(bus_i), .bus_o(bus_o),
    .src_i(src_i), .src_ready(src_ready), .src_part(src_part),
    .rx_o(rx_o), .enc_sel(enc_sel));
  ibmta_peer i_ibmta_peer (.ref_clk(ref_clk), .rst_n(rst_n),
    .present(present), .slow(slow), .bus_o(bus_o), .bus_i(bus_i));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Byte source and receive monitor
  // ----------------------------------------------------------------
  assign src_i = {BASE[src_part] + {4'h0, src_idx},
    src_idx == LEN[src_part] - 4'h1, src_en};

  // src_ready trails the take by one edge, when the part may have moved on,
  // so the last flag and part are kept as they stood at the take
  always @(posedge ref_clk)
  begin
    took_q <= {src_i.last, src_part};
    if (rx_o.valid) rxq.push_back({rx_o.msg_end, rx_o.data});
    if (src_ready)
    begin
      src_idx <= took_q[2] ? 4'h0 : src_idx + 4'h1;
      if (took_q[2] && took_q[1:0] != PART_HEADER) src_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdv, exp);
  endtask

  // Poll busy under a bound rather than a guessed delay
  task automatic wait_idle();
    int i;
    for (i = 0; i < 100; i++)
    begin
      rd(OFS_STATUS);
      if (rdv[ST_BUSY_BIT] === 1'b0) break;
    end
    chk({31'h0, rdv[ST_BUSY_BIT]}, 32'h0);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic add_part(input logic [1:0] p, input bit fin);
    int i;
    for (i = 0; i < LEN[p]; i++)
      exq.push_back({fin && i == LEN[p] - 1 && !term_now, BASE[p] + 8'(i)});
    if (fin && term_now)
    begin
      exq.push_back({1'b0, CHR_CR});
      exq.push_back({1'b1, CHR_LF});
    end
  endtask

  task automatic cmp_out(input bit from_rx);
    logic [8:0] q[$];
    int i;
    if (from_rx)
      q = rxq;
    else
      q = i_ibmta_peer.got;
    chk(32'(q.size()), 32'(exq.size()));
    for (i = 0; i < q.size() && i < exq.size(); i++)
      chk({23'h0, q[i]}, {23'h0, exq[i]});
    exq.delete();
    rxq.delete();
    i_ibmta_peer.got.delete();
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: whole sequence needs well under 5000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int c;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    present = 1'b1;
    slow = 1'b0;
    src_en = 1'b0;
    src_idx = 4'h0;
    term_now = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset state, unmapped and write-only places
    rdchk(OFS_STATUS, 32'h0000_0100);
    rdchk(OFS_MODE, 32'h0000_0002);
    rdchk(4'h2, 32'h0);
    rdchk(OFS_CTRL, 32'h0);
    // Address range edge
    wr(OFS_BUSCFG, 32'h0000_1e00);
    rdchk(OFS_STATUS, 32'h0000_1e00);
    wr(OFS_BUSCFG, 32'h0000_1f00);
    rdchk(OFS_STATUS, 32'h0000_1e00);
    wr(OFS_BUSCFG, 32'h0000_0500);
    // Listen addressing and input message ends
    i_ibmta_peer.send(1'b1, 8'h26, 1'b0);
    rdchk(OFS_STATUS, 32'h0000_0500);
    i_ibmta_peer.send(1'b1, 8'h25, 1'b0);
    rdchk(OFS_STATUS, 32'h0008_0500);
    i_ibmta_peer.send(1'b1, 8'h04, 1'b0);
    rdchk(OFS_MODE, 32'h0000_0002);
    i_ibmta_peer.send(1'b0, 8'h0a, 1'b0);
    i_ibmta_peer.send(1'b0, 8'h41, 1'b1);
    wr(OFS_BUSCFG, 32'h0000_0501);
    term_now = 1'b1;
    i_ibmta_peer.send(1'b0, 8'h0a, 1'b0);
    repeat (2) @(posedge ref_clk);
    exq = '{9'h00a, 9'h141, 9'h10a};
    cmp_out(1'b1);
    // Talker reply with CR LF ending
    i_ibmta_peer.send(1'b1, 8'h3f, 1'b0);
    i_ibmta_peer.send(1'b1, 8'h45, 1'b0);
    rdchk(OFS_STATUS, 32'h0004_0501);
    @(posedge ref_clk);
    src_en <= 1'b1;
    wait_idle();
    add_part(PART_REPLY, 1'b1);
    cmp_out(1'b0);
    wr(OFS_CTRL, 32'h2);
    rdchk(OFS_STATUS, 32'h0014_0501);
    i_ibmta_peer.send(1'b1, 8'h5f, 1'b0);
    rdchk(OFS_STATUS, 32'h0010_0501);
    // Detached: lines released, settings held pending
    wr(OFS_MODE, {29'h0, ROLE_DETACHED});
    // Service request drops one edge after the role itself
    @(posedge ref_clk);
    #1;
    chk({28'h0, bus_o.dio_oe, bus_o.eoi_oe, bus_o.dav_oe, bus_o.srq_oe},
      32'h0);
    wr(OFS_BUSCFG, 32'h0000_0902);
    rdchk(OFS_STATUS, 32'h0000_0501);
    chk({31'h0, enc_sel}, 32'h0);
    @(posedge ref_clk);
    src_en <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    wait_idle();
    cmp_out(1'b0);
    // Talk-only: permanent talker, deaf to commands, no service request
    wr(OFS_MODE, {29'h0, ROLE_TALK_ONLY});
    term_now = 1'b0;
    i_ibmta_peer.send(1'b1, 8'h29, 1'b0);
    wr(OFS_CTRL, 32'h2);
    rdchk(OFS_STATUS, 32'h0004_0902);
    chk({31'h0, enc_sel}, 32'h1);
    present <= 1'b0;
    wr(OFS_CTRL, 32'h1);
    wait_idle();
    rdchk(OFS_STATUS, 32'h0005_0902);
    exq.delete();
    cmp_out(1'b0);
    wr(OFS_CTRL, 32'h4);
    rdchk(OFS_STATUS, 32'h0004_0902);
    present <= 1'b1;
    // Each content option, odd ones against a slow listener
    for (c = 0; c < 3; c++)
    begin
      slow <= c[0];
      // The last pass runs the hard-copy role, which transmits alike
      wr(OFS_MODE, (32'(c) << CONTENT_LSB) |
        (c == 2 ? 32'(ROLE_HARDCOPY) : 32'h0));
      src_en <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      wait_idle();
      if (c == 1) add_part(PART_HEADER, 1'b0);
      add_part(c == 2 ? PART_PROGRAM : PART_SAMPLES, 1'b1);
      cmp_out(1'b0);
    end
    slow <= 1'b0;
    // Listen-only: takes bytes, never sends
    wr(OFS_MODE, {29'h0, ROLE_LISTEN_ONLY});
    i_ibmta_peer.send(1'b0, 8'h33, 1'b1);
    src_en <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    wait_idle();
    exq = '{9'h133};
    cmp_out(1'b1);
    cmp_out(1'b0);
    chk({31'h0, bus_o.srq}, 32'h0);
    chk(32'(i_ibmta_peer.msgs), 32'h4);
    close_out();
  end
endmodule

`default_nettype wire
